/* inc/cdc_pkg.sv */
// Functional notes
// R01: Output low for low count plus one cycles
// R02: Output high for high count plus one cycles
// R03: Divider 2 counts reset to one each
// R04: Bypass powers divider down, passes input through
// R05: Sync mask clear obeys chip sync
// R06: Force acts only with sync mask set
// R07: Forced level low, or start level if set
// R08: Force ignored while bypassed
// R09: Start level bit picks initial output level
// R10: Phase offset delays output, resets zero
// R11: Channel power-down parks three outputs safely
// R12: Direct route with select 10b uses oscillator
// R13: Direct route with select 00b uses clock input
// R14: Direct route with select 01b changes nothing
// R15: Correction disable bit turns off duty fix
// R16: Period is low plus high plus two; outputs share it
// R17: Sync restarts at start level after offset
package cdc_pkg;
  // ==========================================================
  // Register map
  localparam logic [9:0] CDC_DIV1_COUNTS_ADDR = 10'h0_193;
  localparam logic [9:0] CDC_DIV1_CTRL_ADDR = 10'h0_194;
  localparam logic [9:0] CDC_CH1_ROUTE_ADDR = 10'h0_195;
  localparam logic [9:0] CDC_DIV2_COUNTS_ADDR = 10'h0_196;
  localparam logic [9:0] CDC_DIV2_CTRL_ADDR = 10'h0_197;
  localparam logic [9:0] CDC_CH2_ROUTE_ADDR = 10'h0_198;
  localparam logic [9:0] CDC_INSEL_ADDR = 10'h0_1E1;
  localparam logic [9:0] CDC_STATUS_ADDR = 10'h0_1F0;
  // ==========================================================
  // Field positions
  localparam int CDC_LOW_MSB = 7;
  localparam int CDC_LOW_LSB = 4;
  localparam int CDC_HIGH_MSB = 3;
  localparam int CDC_HIGH_LSB = 0;
  localparam int CDC_BYPASS_BIT = 7;
  localparam int CDC_MASK_BIT = 6;
  localparam int CDC_FORCE_BIT = 5;
  localparam int CDC_START_BIT = 4;
  localparam int CDC_PD_BIT = 2;
  localparam int CDC_DIRECT_BIT = 1;
  localparam int CDC_DCCDIS_BIT = 0;
  // ==========================================================
  // Reset values, route write mask and input select codes
  localparam logic [7:0] CDC_DIV1_COUNTS_RST = 8'h33;
  localparam logic [7:0] CDC_DIV2_COUNTS_RST = 8'h11;
  localparam logic [7:0] CDC_CTRL_RST = 8'h00;
  localparam logic [7:0] CDC_ROUTE_RST = 8'h00;
  localparam logic [7:0] CDC_ROUTE_MASK = 8'h07;
  localparam logic [1:0] CDC_INSEL_RST = 2'h1;
  localparam logic [1:0] CDC_SEL_CLK = 2'h0;
  localparam logic [1:0] CDC_SEL_DIV = 2'h1;
  localparam logic [1:0] CDC_SEL_OSC = 2'h2;

  typedef struct packed {
    logic [3:0] low_cnt;
    logic [3:0] high_cnt;
    logic bypass;
    logic sync_mask;
    logic force_en;
    logic start_high;
    logic [3:0] phase;
  } cdc_div_cfg_s;

  typedef enum logic [1:0] {CDC_RUN, CDC_DELAY} cdc_state_e;
endpackage

/* rtl/cdc_divider.sv */
`timescale 1ns/10ps
module cdc_divider
  import cdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sync_pulse,
  input wire cdc_div_cfg_s cfg,
  output logic div_out,
  output logic run_busy
);
  cdc_state_e state_ff;
  logic [3:0] cnt_ff;
  logic lvl_ff;
  logic do_sync;

  assign do_sync = sync_pulse && !cfg.sync_mask; // R05
  assign run_busy = (state_ff == CDC_DELAY);

  // ==========================================================
  // Counter
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_ff <= CDC_RUN;
      cnt_ff <= 4'h0;
      lvl_ff <= 1'b0;
    end else if (cfg.bypass) begin
      state_ff <= CDC_RUN; // R04
      cnt_ff <= 4'h0;
      lvl_ff <= cfg.start_high;
    end else if (do_sync) begin
      state_ff <= CDC_DELAY; // R17
      cnt_ff <= cfg.phase; // R10
      lvl_ff <= cfg.start_high; // R09
    end else begin
      unique case (state_ff)
        CDC_DELAY: begin
          if (cnt_ff == 4'h0) begin
            state_ff <= CDC_RUN;
            cnt_ff <= cfg.start_high ? cfg.high_cnt : cfg.low_cnt;
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        CDC_RUN: begin
          if (cnt_ff == 4'h0) begin
            lvl_ff <= !lvl_ff; // R16
            cnt_ff <= lvl_ff ? cfg.low_cnt : cfg.high_cnt; // R01 R02
          end else begin
            cnt_ff <= cnt_ff - 4'h1;
          end
        end
        default: state_ff <= CDC_RUN;
      endcase
    end
  end

  // ==========================================================
  // Output select
  always_comb begin
    if (cfg.bypass) begin
      div_out = 1'b1; // R04 R08
    end else if (cfg.force_en && cfg.sync_mask) begin
      div_out = cfg.start_high; // R06 R07
    end else if (cfg.sync_mask && !cfg.force_en) begin
      div_out = (state_ff == CDC_DELAY) ? cfg.start_high : lvl_ff;
    end else begin
      div_out = (state_ff == CDC_DELAY) ? cfg.start_high : lvl_ff; // R17
    end
  end
endmodule

/* rtl/cdc_route.sv */
`timescale 1ns/10ps
module cdc_route
  import cdc_pkg::*;
(
  input wire logic div_out,
  input wire logic bypass,
  input wire logic clk_in_level,
  input wire logic osc_level,
  input wire logic [7:0] route,
  input wire logic [1:0] in_sel,
  output logic [2:0] chan_out
);
  logic src;

  always_comb begin
    src = bypass ? clk_in_level : div_out; // R04
    if (route[CDC_DIRECT_BIT]) begin
      unique case (in_sel)
        CDC_SEL_OSC: src = osc_level; // R12
        CDC_SEL_CLK: src = clk_in_level; // R13
        default: ; // R14
      endcase
    end
    if (route[CDC_PD_BIT]) begin
      chan_out = 3'b000; // R11
    end else begin
      chan_out = {3{src}}; // R16
    end
  end
endmodule

/* rtl/cdc_channel_ctrl.sv */
`timescale 1ns/10ps
module cdc_channel_ctrl
  import cdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic sync_in,
  input wire logic clk_in_level,
  input wire logic osc_level,
  output logic [7:0] rdata,
  output logic [2:0] chan1_out,
  output logic [2:0] chan2_out,
  output logic chan1_dcc_on,
  output logic chan2_dcc_on
);
  // ==========================================================
  // Registers
  logic [7:0] div1_counts_ff;
  logic [7:0] div1_ctrl_ff;
  logic [7:0] chan1_route_ff;
  logic [7:0] div2_counts_ff;
  logic [7:0] div2_ctrl_ff;
  logic [7:0] chan2_route_ff;
  logic [1:0] insel_ff;
  logic [7:0] nxt_rdata;
  cdc_div_cfg_s cfg1;
  cdc_div_cfg_s cfg2;
  logic d1_out;
  logic d2_out;
  logic d1_busy;
  logic d2_busy;
  logic [2:0] nxt_c1;
  logic [2:0] nxt_c2;

  function automatic cdc_div_cfg_s cdc_cfg(input logic [7:0] cnt, input logic [7:0] ctl);
    cdc_div_cfg_s c;
    c.low_cnt = cnt[CDC_LOW_MSB:CDC_LOW_LSB];
    c.high_cnt = cnt[CDC_HIGH_MSB:CDC_HIGH_LSB];
    c.bypass = ctl[CDC_BYPASS_BIT];
    c.sync_mask = ctl[CDC_MASK_BIT];
    c.force_en = ctl[CDC_FORCE_BIT];
    c.start_high = ctl[CDC_START_BIT];
    c.phase = ctl[3:0];
    return c;
  endfunction

  assign cfg1 = cdc_cfg(div1_counts_ff, div1_ctrl_ff);
  assign cfg2 = cdc_cfg(div2_counts_ff, div2_ctrl_ff);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      div1_counts_ff <= CDC_DIV1_COUNTS_RST;
      div1_ctrl_ff <= CDC_CTRL_RST;
      chan1_route_ff <= CDC_ROUTE_RST;
      div2_counts_ff <= CDC_DIV2_COUNTS_RST; // R03
      div2_ctrl_ff <= CDC_CTRL_RST; // R10
      chan2_route_ff <= CDC_ROUTE_RST;
      insel_ff <= CDC_INSEL_RST;
    end else if (wr) begin
      unique case (addr)
        CDC_DIV1_COUNTS_ADDR: div1_counts_ff <= wdata;
        CDC_DIV1_CTRL_ADDR: div1_ctrl_ff <= wdata;
        CDC_CH1_ROUTE_ADDR: chan1_route_ff <= wdata & CDC_ROUTE_MASK;
        CDC_DIV2_COUNTS_ADDR: div2_counts_ff <= wdata;
        CDC_DIV2_CTRL_ADDR: div2_ctrl_ff <= wdata;
        CDC_CH2_ROUTE_ADDR: chan2_route_ff <= wdata & CDC_ROUTE_MASK;
        CDC_INSEL_ADDR: insel_ff <= wdata[1:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // Read back
  always_comb begin
    unique case (addr)
      CDC_DIV1_COUNTS_ADDR: nxt_rdata = div1_counts_ff;
      CDC_DIV1_CTRL_ADDR: nxt_rdata = div1_ctrl_ff;
      CDC_CH1_ROUTE_ADDR: nxt_rdata = chan1_route_ff;
      CDC_DIV2_COUNTS_ADDR: nxt_rdata = div2_counts_ff;
      CDC_DIV2_CTRL_ADDR: nxt_rdata = div2_ctrl_ff;
      CDC_CH2_ROUTE_ADDR: nxt_rdata = chan2_route_ff;
      CDC_INSEL_ADDR: nxt_rdata = {6'h00, insel_ff};
      CDC_STATUS_ADDR: nxt_rdata = {4'h0, d2_busy, d1_busy, d2_out, d1_out};
      default: nxt_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata <= 8'h00;
    end else begin
      rdata <= rd ? nxt_rdata : 8'h00;
    end
  end

  // ==========================================================
  // Dividers and routing
  cdc_divider u_div1 (
    .clk(clk),
    .rst(rst),
    .sync_pulse(sync_in),
    .cfg(cfg1),
    .div_out(d1_out),
    .run_busy(d1_busy)
  );

  cdc_divider u_div2 (
    .clk(clk),
    .rst(rst),
    .sync_pulse(sync_in),
    .cfg(cfg2),
    .div_out(d2_out),
    .run_busy(d2_busy)
  );

  cdc_route u_rt1 (
    .div_out(d1_out),
    .bypass(cfg1.bypass),
    .clk_in_level(clk_in_level),
    .osc_level(osc_level),
    .route(chan1_route_ff),
    .in_sel(insel_ff),
    .chan_out(nxt_c1)
  );

  cdc_route u_rt2 (
    .div_out(d2_out),
    .bypass(cfg2.bypass),
    .clk_in_level(clk_in_level),
    .osc_level(osc_level),
    .route(chan2_route_ff),
    .in_sel(insel_ff),
    .chan_out(nxt_c2)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan1_out <= 3'b000;
      chan2_out <= 3'b000;
      chan1_dcc_on <= 1'b1;
      chan2_dcc_on <= 1'b1;
    end else begin
      chan1_out <= nxt_c1;
      chan2_out <= nxt_c2;
      chan1_dcc_on <= !chan1_route_ff[CDC_DCCDIS_BIT]; // R15
      chan2_dcc_on <= !chan2_route_ff[CDC_DCCDIS_BIT]; // R15
    end
  end
endmodule

/* sim/cdc_properties.sv */
`timescale 1ns/10ps
module cdc_checker
  import cdc_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [9:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [2:0] chan1_out,
  input wire logic [2:0] chan2_out,
  input wire logic chan1_dcc_on
);
  logic [7:0] ctl1_ff;
  logic [2:0] rt1_ff;
  logic [7:0] cnt2_ff;
  logic frc1;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Register shadows
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl1_ff <= CDC_CTRL_RST;
      rt1_ff <= 3'h0;
      cnt2_ff <= CDC_DIV2_COUNTS_RST;
    end else if (wr) begin
      if (addr == CDC_DIV1_CTRL_ADDR) ctl1_ff <= wdata;
      if (addr == CDC_CH1_ROUTE_ADDR) rt1_ff <= wdata[2:0];
      if (addr == CDC_DIV2_COUNTS_ADDR) cnt2_ff <= wdata;
    end
  end
  assign frc1 = (ctl1_ff[7:5] == 3'b011) && (rt1_ff[2:1] == 2'b00);
  // ====
  // Properties
  sequence s_frc1; frc1 [*5]; endsequence
  sequence s_pd1; rt1_ff[2] [*4]; endsequence
  sequence s_dcc1; $stable(rt1_ff[0]) [*3]; endsequence
  property p_cnt2_rd; rd && addr == CDC_DIV2_COUNTS_ADDR |=> rdata == $past(cnt2_ff); endproperty
  property p_ctl1_rd; rd && addr == CDC_DIV1_CTRL_ADDR |=> rdata == $past(ctl1_ff); endproperty
  property p_rt1_rd; rd && addr == CDC_CH1_ROUTE_ADDR |=> rdata == {5'h00, $past(rt1_ff)}; endproperty
  property p_pd1; s_pd1 |-> chan1_out == 3'h0; endproperty
  property p_frc1; s_frc1 |-> chan1_out == {3{ctl1_ff[4]}}; endproperty
  property p_dcc1; s_dcc1 |-> chan1_dcc_on == !rt1_ff[0]; endproperty
  property p_share1; chan1_out == 3'h0 || chan1_out == 3'h7; endproperty
  property p_share2; chan2_out == 3'h0 || chan2_out == 3'h7; endproperty
  a_cnt2_rd: assert property (p_cnt2_rd) else $error("div2 counts readback wrong");
  a_ctl1_rd: assert property (p_ctl1_rd) else $error("div1 control readback wrong");
  a_rt1_rd: assert property (p_rt1_rd) else $error("ch1 route readback wrong");
  a_pd1: assert property (p_pd1) else $error("ch1 not parked");
  a_frc1: assert property (p_frc1) else $error("ch1 forced level wrong");
  a_dcc1: assert property (p_dcc1) else $error("ch1 duty fix state wrong");
  a_share1: assert property (p_share1) else $error("ch1 outputs differ");
  a_share2: assert property (p_share2) else $error("ch2 outputs differ");
endmodule

bind cdc_channel_ctrl cdc_checker cdc_checker_i (.clk, .rst, .addr, .wdata, .wr, .rd, .rdata,
  .chan1_out, .chan2_out, .chan1_dcc_on);

/* sim/tb_cdc_channel_ctrl.sv */
`timescale 1ns/10ps
module tb_cdc_channel_ctrl;
  import cdc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [9:0] addr = 10'h0_000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic sync_in = 1'b0;
  logic clk_in_level = 1'b0;
  logic osc_level = 1'b0;
  logic [7:0] rdata;
  logic [2:0] chan1_out;
  logic [2:0] chan2_out;
  logic chan1_dcc_on;
  logic chan2_dcc_on;
  int error_cnt = 0;
  int checked = 0;
  int cyc = 0;
  logic [9:0] ra [8] = '{10'h0_193, 10'h0_194, 10'h0_195, 10'h0_196, 10'h0_197, 10'h0_198,
    10'h0_1E1, 10'h0_000};
  logic [7:0] re [8] = '{8'h33, 8'h00, 8'h00, 8'h11, 8'h00, 8'h00, 8'h01, 8'h00};
  cdc_channel_ctrl cdc_channel_ctrl_i (.clk, .rst, .addr, .wdata, .wr, .rd, .sync_in,
    .clk_in_level, .osc_level, .rdata, .chan1_out, .chan2_out, .chan1_dcc_on, .chan2_dcc_on);
  always #2.5 clk = ~clk;
  // ====
  // Tasks
  task automatic final_report();
    $display("errors %0d checks %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wreg(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [9:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk(rdata, e);
  endtask
  task automatic lvl(input logic [2:0] e);
    repeat (6) @(posedge clk);
    #1 chk({5'h00, chan1_out}, {5'h00, e});
    @(posedge clk);
  endtask
  // Lets a new count setting take over, then times one whole phase of level v
  task automatic meas(input logic v, input int e);
    int k;
    k = 0;
    repeat (16) @(posedge clk);
    #1;
    while (chan2_out[0] === v) begin
      @(posedge clk);
      #1;
    end
    while (chan2_out[0] !== v) begin
      @(posedge clk);
      #1;
    end
    while (chan2_out[0] === v) begin
      @(posedge clk);
      #1;
      k++;
    end
    chk(k[7:0], e[7:0]);
  endtask
  task automatic syn(input logic [7:0] c, input logic [2:0] e);
    wreg(CDC_DIV2_CTRL_ADDR, c);
    sync_in <= 1'b1;
    @(posedge clk);
    sync_in <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({5'h00, chan2_out}, {5'h00, e});
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      final_report();
    end
  end
  // ====
  // Sequence
  initial begin
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      rreg(ra[i], re[i]);
    end
    wreg(CDC_CH1_ROUTE_ADDR, 8'hFF);
    rreg(CDC_CH1_ROUTE_ADDR, 8'h07);
    lvl(3'h0);
    chk({7'h00, chan1_dcc_on}, 8'h00);
    chk({7'h00, chan2_dcc_on}, 8'h01);
    wreg(CDC_CH1_ROUTE_ADDR, 8'h00);
    wreg(CDC_DIV2_COUNTS_ADDR, 8'h24);
    meas(1'b1, 5);
    meas(1'b0, 3);
    syn(8'h13, 3'h7);
    syn(8'h03, 3'h0);
    wreg(CDC_DIV1_CTRL_ADDR, 8'h70);
    lvl(3'h7);
    wreg(CDC_DIV1_CTRL_ADDR, 8'hF0);
    clk_in_level <= 1'b1;
    lvl(3'h7);
    clk_in_level <= 1'b0;
    lvl(3'h0);
    wreg(CDC_DIV1_CTRL_ADDR, 8'h00);
    wreg(CDC_CH1_ROUTE_ADDR, 8'h02);
    wreg(CDC_INSEL_ADDR, 8'h00);
    clk_in_level <= 1'b1;
    lvl(3'h7);
    clk_in_level <= 1'b0;
    osc_level <= 1'b1;
    lvl(3'h0);
    wreg(CDC_INSEL_ADDR, 8'h02);
    lvl(3'h7);
    osc_level <= 1'b0;
    wreg(CDC_DIV1_CTRL_ADDR, 8'h70);
    wreg(CDC_INSEL_ADDR, 8'h01);
    lvl(3'h7);
    wreg(CDC_CH2_ROUTE_ADDR, 8'h01);
    rreg(CDC_CH2_ROUTE_ADDR, 8'h01);
    chk({7'h00, chan2_dcc_on}, 8'h00);
    wreg(CDC_DIV2_CTRL_ADDR, 8'h70);
    rreg(CDC_STATUS_ADDR, 8'h03);
    // Reset in mid-run must bring the channel 2 registers back to their defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rreg(CDC_DIV2_CTRL_ADDR, 8'h00);
    rreg(CDC_CH2_ROUTE_ADDR, 8'h00);
    chk({7'h00, chan2_dcc_on}, 8'h01);
    rreg(CDC_DIV2_COUNTS_ADDR, 8'h11);
    final_report();
  end
endmodule
